// file: sim/snv_ctrl_bench.sv
// self-checking bench for the serial memory control block
// assumes: master model drives the serial pins, bench the rest
`timescale 1ns/1ps
module snv_ctrl_bench;
  import snv_pkg::*;
  logic mclk_i, rst_i, wp_n, pfail, sb_low, sb_wire;
  logic so_o, so_oe_o, store_busy_pin_o, store_busy_pin_oe_o;
  logic sck, cs_n, si, hold_n;
  logic [7:0] rx;
  int mismatches, n_checks;
  snv_pins_t pins;
  // pulled-up wire, low when either side pulls it
  assign sb_wire = ~((store_busy_pin_oe_o & ~store_busy_pin_o) | sb_low);
  assign pins = {sck, cs_n, si, hold_n, wp_n, sb_wire, pfail};
  snv_ctrl DUT (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .pins_i(pins),
    .so_o(so_o),
    .so_oe_o(so_oe_o),
    .store_busy_pin_o(store_busy_pin_o),
    .store_busy_pin_oe_o(store_busy_pin_oe_o)
  );
  snv_master m (
    .mclk_i(mclk_i),
    .so_i(so_o),
    .sck_o(sck),
    .cs_n_o(cs_n),
    .si_o(si),
    .hold_n_o(hold_n)
  );
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for the busy pin drive to reach a level
  task automatic wait_oe(input logic v, input int lim);
    int k;
    k = 0;
    while (store_busy_pin_oe_o !== v && k < lim) begin
      m.tick(1);
      k++;
    end
    chk({7'h00, store_busy_pin_oe_o}, {7'h00, v});
    if (k >= lim) begin
      $display("BAD %0t busy pin wait ran out", $time);
      mismatches++;
      results();
    end
  endtask
  task automatic do_reset();
    rst_i = 1'b1;
    m.tick(12);
    rst_i = 1'b0;
    m.tick(300);
  endtask
  task automatic frame(input logic [7:0] op, input logic [7:0] b, int n);
    m.sel();
    m.xfer(op, rx);
    if (n > 1)
      m.xfer(b, rx);
    m.desel();
  endtask
  task automatic status_read_cmd();
    frame(8'h05, 8'h00, 2);
  endtask
  task automatic acc(input logic [7:0] op, input logic [7:0] a,
                     input logic [7:0] d);
    if (op == 8'h02)
      frame(8'h06, 8'h00, 1);
    m.sel();
    m.xfer(op, rx);
    m.xfer(8'h00, rx);
    m.xfer(8'h00, rx);
    m.xfer(a, rx);
    m.xfer(d, rx);
    m.desel();
  endtask
  task automatic t_protect();
    status_read_cmd();
    chk(rx, 8'h00);
    wp_n = 1'b0;
    acc(8'h02, 8'h00, 8'hA5);
    acc(8'h03, 8'h00, 8'h00);
    chk(rx, 8'hA5);
    frame(8'h06, 8'h00, 1);
    frame(8'h01, 8'h80, 2);
    status_read_cmd();
    chk(rx, 8'h80);
    acc(8'h02, 8'h00, 8'h5A);
    acc(8'h03, 8'h00, 8'h00);
    chk(rx, 8'hA5);
    frame(8'h06, 8'h00, 1);
    frame(8'h01, 8'h00, 2);
    status_read_cmd();
    chk(rx, 8'h80);
    wp_n = 1'b1;
  endtask
  task automatic t_pause();
    m.pause_en = 1'b1;
    acc(8'h03, 8'h00, 8'h00);
    m.pause_en = 1'b0;
    chk(rx, 8'hA5);
  endtask
  task automatic t_cmd_save();
    frame(8'h3C, 8'h00, 1);
    chk({6'h00, store_busy_pin_oe_o, store_busy_pin_o}, 8'h02);
    frame(8'h06, 8'h00, 1);
    status_read_cmd();
    chk(rx, 8'h81);
    wait_oe(1'b0, 300);
    status_read_cmd();
    chk(rx, 8'h80);
  endtask
  task automatic t_pin_save();
    sb_low = 1'b1;
    m.tick(4);
    sb_low = 1'b0;
    wait_oe(1'b1, 20);
    wait_oe(1'b0, 300);
  endtask
  task automatic t_pfail_save();
    pfail = 1'b1;
    wait_oe(1'b1, 20);
    wait_oe(1'b0, 300);
    pfail = 1'b0;
  endtask
  task automatic t_recall();
    // unsaved write must be replaced by the saved byte
    acc(8'h02, 8'h00, 8'h66);
    acc(8'h03, 8'h00, 8'h00);
    chk(rx, 8'h66);
    do_reset();
    acc(8'h03, 8'h00, 8'h00);
    chk(rx, 8'hA5);
    status_read_cmd();
    chk(rx, 8'h00);
  endtask
  initial begin
    mismatches = 0;
    n_checks = 0;
    wp_n = 1'b1;
    pfail = 1'b0;
    sb_low = 1'b0;
    rst_i = 1'b1;
    do_reset();
    t_protect();
    t_pause();
    t_cmd_save();
    t_pin_save();
    t_pfail_save();
    t_recall();
    results();
  end
endmodule

// file: sim/snv_master.sv
// spi master model, mode 0
// assumes: sck period of 8 mclk cycles
`timescale 1ns/1ps
module snv_master (
  input wire logic mclk_i,
  input wire logic so_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  output logic hold_n_o
);
  logic pause_en;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    hold_n_o = 1'b1;
    pause_en = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // read at the fall: so settles 3 mclk after a fall
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (pause_en && i == 3) begin
        // let the last fall be seen before pausing
        tick(4);
        hold_n_o = 1'b0;
        si_o = ~tx[i];
        repeat (3) begin
          tick(4);
          sck_o = 1'b1;
          tick(4);
          sck_o = 1'b0;
        end
        tick(4);
        hold_n_o = 1'b1;
      end
      si_o = tx[i];
      tick(4);
      sck_o = 1'b1;
      tick(4);
      rx[i] = so_i;
      sck_o = 1'b0;
    end
  endtask
  task automatic sel();
    cs_n_o = 1'b0;
    tick(4);
  endtask
  task automatic desel();
    tick(4);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    tick(8);
  endtask
endmodule

// file: src/snv_ctrl.sv
// serial memory slave with pause, write protect, save and copy-back
// assumes: spi mode 0 master, sck well below a quarter of mclk_i
`timescale 1ns/1ps
`include "snv_regs.svh"
// Notes on behaviour
// - pause low freezes transfer, clock ignored
// - protect pin low blocks array, status writes
// - protect pin effective only when enable set
// - busy pin shows busy during save
// - while saving only status read accepted
// - status busy bit set during save
// - busy pin pulled low starts save
// - save on power-fail, command or pin
// - power-up copies cells back before access
// - reads and writes reach volatile array only
// - transfers need select low; rising ends
// - opcode 05H returns status byte
module snv_ctrl #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input snv_pkg::snv_pins_t pins_i,
  output logic so_o,
  output logic so_oe_o,
  output logic store_busy_pin_o,
  output logic store_busy_pin_oe_o
);
  import snv_pkg::*;

  generate
    if (DEPTH != (1 << AW) || AW > 24 || AW < 1) begin : g_bad
      $error("depth must be a power of two, address up to 24 bits");
    end
  endgenerate

  snv_state_t q, d;
  snv_pins_t pin_s;
  logic [7:0] mem [DEPTH];
  logic nv_store, nv_recall, nv_we, nv_busy;
  logic [AW-1:0] nv_addr;
  logic [7:0] nv_wd, nv_rd;
  logic spi_we;
  logic [AW-1:0] spi_wa;
  logic [7:0] spi_wd;
  logic sck_rise, sck_fall, act, wr_ok, byte_end;
  logic hw_req, pf_req;
  logic [7:0] byte_v;

  function automatic logic [7:0] status_byte(input logic ppe,
      input logic wen, input logic busy);
    logic [7:0] s;
    s = `SNV_SR_RESET;
    s[`SNV_SR_PPE] = ppe;
    s[`SNV_SR_WEN] = wen;
    s[`SNV_SR_BUSY] = busy;
    return s;
  endfunction

  snv_sync u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i(pins_i),
    .q_o(pin_s)
  );

  snv_nvstore #(.DEPTH(DEPTH), .AW(AW)) u_nv (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .store_i(q.store_req),
    .rdata_i(nv_rd),
    .store_o(nv_store),
    .recall_o(nv_recall),
    .we_o(nv_we),
    .addr_o(nv_addr),
    .wdata_o(nv_wd)
  );

  assign nv_busy = nv_store | nv_recall;
  assign nv_rd = mem[nv_addr];

  always_comb begin
    logic [23:0] ra;
    logic [7:0] rdat;
    ra = `SNV_ADDR_RESET;
    rdat = 8'h00;
    d = q;
    spi_we = 1'b0;
    spi_wa = q.addr[AW-1:0];
    spi_wd = 8'h00;
    byte_v = {q.shin[6:0], pin_s.si};
    sck_rise = pin_s.sck & ~q.sck_prev;
    sck_fall = ~pin_s.sck & q.sck_prev;
    // clock edges count only with select low and pause released
    act = ~pin_s.cs_n & pin_s.hold_n;
    wr_ok = q.wen & ~(q.ppe & ~pin_s.wp_n);
    byte_end = act & sck_rise & ~nv_recall & (q.bitcnt == `SNV_LAST_BIT);
    d.sck_prev = pin_s.sck;
    d.busy_prev = pin_s.store_busy_pin;
    d.pf_prev = pin_s.pfail;
    d.store_req = 1'b0;
    // own drive is masked so its own pull-down is not taken as a request
    hw_req = q.busy_prev & ~pin_s.store_busy_pin & ~q.busy_oe;
    pf_req = pin_s.pfail & ~q.pf_prev;
    if (hw_req | pf_req) begin
      d.store_req = 1'b1;
    end
    if (q.phase == PH_ADDR) begin
      ra = {q.addr[15:0], byte_v};
    end else begin
      ra = q.addr + `SNV_ADDR_STEP;
    end
    rdat = mem[ra[AW-1:0]];
    if (pin_s.cs_n) begin
      d.phase = PH_CMD;
      d.bitcnt = `SNV_FIRST_BIT;
      d.so_oe = 1'b0;
      if (q.clr_wen) begin
        d.wen = 1'b0;
        d.clr_wen = 1'b0;
      end
    end else if (act && sck_rise && !nv_recall) begin
      d.shin = byte_v;
      d.bitcnt = q.bitcnt + 3'h1;
      if (byte_end) begin
        case (q.phase)
          PH_CMD: begin
            d.opcode = byte_v;
            if (nv_busy && byte_v != `SNV_OP_RDST) begin
              d.phase = PH_DONE;
            end else if (byte_v == `SNV_OP_RDST) begin
              d.phase = PH_DATA;
              d.shout = status_byte(q.ppe, q.wen, nv_busy);
            end else if (byte_v == `SNV_OP_WREN) begin
              d.wen = 1'b1;
              d.phase = PH_DONE;
            end else if (byte_v == `SNV_OP_WRDI) begin
              d.wen = 1'b0;
              d.phase = PH_DONE;
            end else if (byte_v == `SNV_OP_WRSR) begin
              d.phase = PH_DATA;
              d.clr_wen = 1'b1;
            end else if (byte_v == `SNV_OP_READ) begin
              d.phase = PH_ADDR;
              d.abyte = 2'h0;
            end else if (byte_v == `SNV_OP_WRITE) begin
              d.phase = PH_ADDR;
              d.abyte = 2'h0;
              d.clr_wen = 1'b1;
            end else if (byte_v == `SNV_OP_STORE) begin
              d.store_req = 1'b1;
              d.phase = PH_DONE;
            end else begin
              d.phase = PH_DONE;
            end
          end
          PH_ADDR: begin
            d.addr = ra;
            d.abyte = q.abyte + 2'h1;
            if (q.abyte == `SNV_LAST_ABYTE) begin
              d.phase = PH_DATA;
              d.shout = rdat;
            end
          end
          PH_DATA: begin
            if (q.opcode == `SNV_OP_RDST) begin
              d.shout = status_byte(q.ppe, q.wen, nv_busy);
            end else if (q.opcode == `SNV_OP_WRSR) begin
              if (wr_ok) begin
                d.ppe = byte_v[`SNV_SR_PPE];
              end
              d.phase = PH_DONE;
            end else if (q.opcode == `SNV_OP_READ) begin
              d.addr = ra;
              d.shout = rdat;
            end else begin
              spi_we = wr_ok;
              spi_wd = byte_v;
              d.addr = ra;
            end
          end
          default: begin
            d.phase = PH_DONE;
          end
        endcase
      end
    end else if (act && sck_fall) begin
      d.so = q.shout[3'h7 - q.bitcnt];
      d.so_oe = (q.phase == PH_DATA) &&
        (q.opcode == `SNV_OP_READ || q.opcode == `SNV_OP_RDST);
    end
    if (!pin_s.hold_n) begin
      d.so_oe = 1'b0;
    end
    // pin pulled low only while saving, released otherwise
    d.busy_oe = nv_store;
    d.busy_out = ~nv_store;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.phase <= PH_CMD;
      q.busy_out <= 1'b1;
      q.busy_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // copy-back takes the port; spi writes are ignored while it runs
  always_ff @(posedge mclk_i) begin
    if (nv_we) begin
      mem[nv_addr] <= nv_wd;
    end else if (spi_we) begin
      mem[spi_wa] <= spi_wd;
    end
  end

  assign so_o = q.so;
  assign so_oe_o = q.so_oe;
  assign store_busy_pin_o = q.busy_out;
  assign store_busy_pin_oe_o = q.busy_oe;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_paused;
    !pin_s.hold_n && !pin_s.cs_n && !$past(pin_s.cs_n);
  endsequence

  sequence s_cmd_byte_busy;
    byte_end && q.phase == PH_CMD && nv_busy;
  endsequence

  a_pause_freeze: assert property (s_paused |->
    $stable(q.bitcnt) && !spi_we)
    else $error("clock counted while paused");

  a_protect_block: assert property (spi_we |->
    q.wen && !(q.ppe && !pin_s.wp_n))
    else $error("write passed protect");

  a_protect_gate: assert property (byte_end &&
    q.phase == PH_DATA && q.opcode == `SNV_OP_WRSR && q.wen && !q.ppe |=>
    q.ppe == $past(byte_v[`SNV_SR_PPE]))
    else $error("enable bit not written while pin disabled");

  a_pin_busy: assert property (nv_store |=>
    store_busy_pin_oe_o && !store_busy_pin_o)
    else $error("busy pin not driven low during save");

  a_pin_release: assert property (!nv_store |=>
    !store_busy_pin_oe_o && store_busy_pin_o)
    else $error("busy pin held after save");

  a_busy_reject: assert property ((s_cmd_byte_busy and
    byte_v != `SNV_OP_RDST) |=> q.phase == PH_DONE)
    else $error("command accepted while busy");

  a_busy_flag: assert property ((s_cmd_byte_busy and
    byte_v == `SNV_OP_RDST) |=> q.shout[`SNV_SR_BUSY])
    else $error("busy flag missing in status");

  a_pin_store: assert property (hw_req && !nv_busy |=>
    q.store_req ##1 nv_store)
    else $error("pin request did not start save");

  a_pfail_store: assert property ($rose(pin_s.pfail) |=>
    q.store_req)
    else $error("power-fail did not request save");

  a_recall_first: assert property (nv_recall |->
    (!spi_we && !$changed(q.phase)) || pin_s.cs_n)
    else $error("access during copy-back");

  a_nv_apart: assert property (nv_store |-> !nv_we)
    else $error("volatile array written during save");

  a_cs_end: assert property ($rose(pin_s.cs_n) |=>
    q.phase == PH_CMD && q.bitcnt == `SNV_FIRST_BIT && !so_oe_o)
    else $error("select rise did not end transfer");
endmodule

// file: src/snv_nvstore.sv
// nonvolatile cell array with save and power-up copy-back sequencer
// assumes: sram read data for addr_o arrives in the same cycle
`timescale 1ns/1ps
`include "snv_regs.svh"
module snv_nvstore #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic store_i,
  input wire logic [7:0] rdata_i,
  output logic store_o,
  output logic recall_o,
  output logic we_o,
  output logic [AW-1:0] addr_o,
  output logic [7:0] wdata_o
);
  import snv_pkg::*;
  logic [7:0] cells [DEPTH];
  snv_nv_state_t q, d;
  logic last;

  assign last = (q.cnt[AW-1:0] == AW'(DEPTH - 1));
  assign store_o = (q.st == NV_STORE);
  assign recall_o = (q.st == NV_RECALL);
  assign we_o = recall_o;
  assign addr_o = q.cnt[AW-1:0];
  assign wdata_o = cells[q.cnt[AW-1:0]];

  always_comb begin
    d = q;
    case (q.st)
      NV_RECALL: begin
        d.cnt = q.cnt + `SNV_ADDR_STEP;
        if (last) begin
          d.st = NV_IDLE;
          d.cnt = `SNV_ADDR_RESET;
        end
      end
      NV_IDLE: begin
        if (store_i) begin
          d.st = NV_STORE;
        end
      end
      default: begin
        d.cnt = q.cnt + `SNV_ADDR_STEP;
        if (last) begin
          d.st = NV_IDLE;
          d.cnt = `SNV_ADDR_RESET;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{NV_RECALL, `SNV_ADDR_RESET};
    end else begin
      q <= d;
    end
  end

  // cells are only touched by save; no reset since they model retention
  always_ff @(posedge mclk_i) begin
    if (q.st == NV_STORE) begin
      cells[q.cnt[AW-1:0]] <= rdata_i;
    end
  end

  a_nv_store_len: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(store_o) |-> store_o [*8])
    else $error("save ended too early");
endmodule

// file: src/snv_pkg.sv
// types shared by the serial nonvolatile memory control block
// assumes: nothing beyond the constants header
package snv_pkg;
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
    logic hold_n;
    logic wp_n;
    logic store_busy_pin;
    logic pfail;
  } snv_pins_t;

  typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_DATA, PH_DONE} snv_phase_t;
  typedef enum logic [1:0] {NV_RECALL, NV_IDLE, NV_STORE} snv_nvst_t;

  typedef struct packed {
    logic sck_prev;
    logic [2:0] bitcnt;
    logic [7:0] shin;
    logic [7:0] shout;
    snv_phase_t phase;
    logic [7:0] opcode;
    logic [1:0] abyte;
    logic [23:0] addr;
    logic wen;
    logic ppe;
    logic clr_wen;
    logic so;
    logic so_oe;
    logic busy_out;
    logic busy_oe;
    logic busy_prev;
    logic pf_prev;
    logic store_req;
  } snv_state_t;

  typedef struct packed {
    snv_nvst_t st;
    logic [23:0] cnt;
  } snv_nv_state_t;
endpackage

// file: src/snv_regs.svh
// constants of the serial nonvolatile memory control block
// assumes: included by bare name from the design modules
`ifndef SNV_REGS_SVH
`define SNV_REGS_SVH
`define SNV_OP_WRSR 8'h01
`define SNV_OP_WRITE 8'h02
`define SNV_OP_READ 8'h03
`define SNV_OP_WRDI 8'h04
`define SNV_OP_RDST 8'h05
`define SNV_OP_WREN 8'h06
`define SNV_OP_STORE 8'h3C
`define SNV_SR_BUSY 0
`define SNV_SR_WEN 1
`define SNV_SR_PPE 7
`define SNV_SR_RESET 8'h00
`define SNV_LAST_BIT 3'h7
`define SNV_FIRST_BIT 3'h0
`define SNV_LAST_ABYTE 2'h2
`define SNV_ADDR_STEP 24'h000001
`define SNV_ADDR_RESET 24'h000000
`endif

// file: src/snv_sync.sv
// two-flop synchroniser for the pin group
// assumes: inputs asynchronous to mclk_i
`timescale 1ns/1ps
module snv_sync (
  input wire logic mclk_i,
  input wire logic rst_i,
  input snv_pkg::snv_pins_t d_i,
  output snv_pkg::snv_pins_t q_o
);
  import snv_pkg::*;
  snv_pins_t meta_q;

  // idle levels: pins high except clock, data in and power-fail
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
      q_o <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule
